// ===== verilog/wlte_regs.vh
// Register offsets, field positions, codes and reset values of the trigger evaluator
`ifndef WLTE_REGS_VH
`define WLTE_REGS_VH

// Byte offsets on the register bus, one aligned 32-bit word each
`define WLTE_OFS_CTRL 5'h00
`define WLTE_OFS_LEVELS 5'h04
`define WLTE_OFS_LOGIC0 5'h08
`define WLTE_OFS_LOGIC1 5'h0c
`define WLTE_OFS_STATUS 5'h10
`define WLTE_OFS_MASK 5'h14
`define WLTE_OFS_STATE 5'h18

// Control register fields
`define WLTE_CTRL_ANA_EN 0
`define WLTE_CTRL_TYPE 1
`define WLTE_CTRL_COMB 2
`define WLTE_CTRL_CHSEL_LSB 4
`define WLTE_CTRL_CHSEL_MSB 5

// Trigger type and combining codes
`define WLTE_TYPE_WINDOW 1'b0
`define WLTE_TYPE_BISLOPE 1'b1
`define WLTE_COMB_OR 1'b0
`define WLTE_COMB_AND 1'b1

// Level register fields, signed percent in two's complement
`define WLTE_LVL_LO_LSB 0
`define WLTE_LVL_LO_MSB 7
`define WLTE_LVL_HI_LSB 8
`define WLTE_LVL_HI_MSB 15

// Logic slot register fields
`define WLTE_LOG_SRC_LSB 0
`define WLTE_LOG_SRC_MSB 1
`define WLTE_LOG_CARE_LSB 8
`define WLTE_LOG_CARE_MSB 15
`define WLTE_LOG_VAL_LSB 16
`define WLTE_LOG_VAL_MSB 23

// Packed slot register: source in [1:0], care mask in [9:2], required values in [17:10]
`define WLTE_SLOT_CARE_LSB 2
`define WLTE_SLOT_CARE_MSB 9
`define WLTE_SLOT_VAL_LSB 10
`define WLTE_SLOT_VAL_MSB 17

// Logic slot source codes
`define WLTE_SRC_OFF 2'h0
`define WLTE_SRC_FIRST 2'h1
`define WLTE_SRC_SECOND 2'h2

// Status and mask bit positions
`define WLTE_EV_TRIG 0
`define WLTE_EV_ORDER 1

// Level limits in percent
`define WLTE_LEVEL_MAX 8'h64
`define WLTE_LEVEL_MIN 8'h9c

// Reset values
`define WLTE_RST_CTRL 6'h00
`define WLTE_RST_LEVEL_LO 8'hce
`define WLTE_RST_LEVEL_HI 8'h32
`define WLTE_RST_LOGIC 18'h00000
`define WLTE_RST_EVENTS 2'h0

`endif

// ===== verilog/wlte_sync2.v
// Two-stage synchroniser for one eight-bit logic input port
`timescale 1ns/1ps
module wlte_sync2 (
    input wire clk_i,
    input wire sys_rst_i,
    input wire [7:0] async_i,
    output reg [7:0] sync_o
);
    reg [7:0] meta; // First stage, read only by the second stage

    // Pins change at any time, so two flops stand before any logic
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            meta <= 8'h00;
            sync_o <= 8'h00;
        end else begin
            meta <= async_i;
            sync_o <= meta;
        end
    end
endmodule // wlte_sync2

// ===== verilog/wlte_level_cmp.v
// Signed comparison of a channel value against one trigger level
`timescale 1ns/1ps
module wlte_level_cmp (
    input wire [7:0] value_i,
    input wire [7:0] level_i,
    output wire above_o,
    output wire below_o
);
    // Strict comparisons: a value equal to the level is neither
    assign above_o = $signed(value_i) > $signed(level_i);
    assign below_o = $signed(value_i) < $signed(level_i);
endmodule // wlte_level_cmp

// ===== verilog/wlte_trigger.v
// Window, bi-slope and logic pattern trigger evaluator with Avalon-MM registers
`timescale 1ns/1ps
`include "wlte_regs.vh"
module wlte_trigger (
    input wire clk_i,
    input wire sys_rst_i,
    // Register bus, Avalon-MM slave
    input wire [4:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    output reg [31:0] avs_readdata_o,
    output reg avs_waitrequest_o,
    // Sampled measurement channels, same clock domain
    input wire sample_en_i,
    input wire [7:0] ch0_value_i,
    input wire [7:0] ch1_value_i,
    input wire [7:0] ch2_value_i,
    input wire [7:0] ch3_value_i,
    // Logic input pins, asynchronous
    input wire [7:0] logic_port_first_i,
    input wire [7:0] logic_port_second_i,
    // Towards the capture controller
    output reg trig_pulse_o,
    output reg irq_o
);
    // Register map, one aligned word per offset:
    //   0x00 control: analog enable, trigger type, combining, channel select
    //   0x04 levels: lower in the low byte, upper in the next byte
    //   0x08 and 0x0c logic slots: source, care mask, required values
    //   0x10 status, write one to clear; 0x14 interrupt mask
    //   0x18 live state: last condition and both synchronised ports
    //   Unmapped offsets read zero and ignore writes
    // Slots are held packed without the unused bits between source and mask,
    // so the slot functions use the packed positions, not the bus positions.
    // Configuration registers
    reg [5:0] ctrl; // Analog enable, type, combining, channel select
    reg [7:0] level_lo; // Lower level, signed percent
    reg [7:0] level_hi; // Upper level, signed percent
    reg [17:0] logic0; // Slot 0: source, care mask, required values
    reg [17:0] logic1; // Slot 1: same layout
    reg [1:0] status; // Sticky events
    reg [1:0] mask; // Interrupt enables

    // Evaluation state
    // Cleared by reset only; a configuration change keeps the history
    reg cond_q; // Combined condition at the last sample
    reg prev_valid; // A previous sample exists for edge detection
    reg prev_below_lo; // Last sample was below the lower level
    reg prev_above_hi; // Last sample was above the upper level

    // Synchronised logic port bits
    // Only the second synchroniser stage is visible here
    wire [7:0] first_port_bits;
    wire [7:0] second_port_bits;

    // Decoded control fields
    // Bit 3 of the control word is stored and read back but has no function
    wire ana_en = ctrl[`WLTE_CTRL_ANA_EN];
    wire trig_type = ctrl[`WLTE_CTRL_TYPE];
    wire comb_and = ctrl[`WLTE_CTRL_COMB];
    wire [1:0] ch_sel = ctrl[`WLTE_CTRL_CHSEL_MSB:`WLTE_CTRL_CHSEL_LSB];

    // Bus decode; a write lands on the edge where the master sees the stall end
    wire bus_req = avs_read_i | avs_write_i;
    // Reads need no strobe: the data were loaded one edge before they are taken
    wire wr_done = avs_write_i & ~avs_waitrequest_o;

    // Clamp a written level into the allowed percent range
    // Saturating rather than rejecting keeps a wild write usable as a full-scale level
    function [7:0] clamp_level;
        input [7:0] raw;
        begin
            if ($signed(raw) > $signed(`WLTE_LEVEL_MAX)) begin
                clamp_level = `WLTE_LEVEL_MAX;
            end else if ($signed(raw) < $signed(`WLTE_LEVEL_MIN)) begin
                clamp_level = `WLTE_LEVEL_MIN;
            end else begin
                clamp_level = raw;
            end
        end
    endfunction

    // Whether a slot takes part in the trigger at all
    function slot_enabled;
        input [17:0] slot;
        reg [1:0] src;
        begin
            src = slot[`WLTE_LOG_SRC_MSB:`WLTE_LOG_SRC_LSB];
            // The unused source code behaves as disabled
            slot_enabled = (src == `WLTE_SRC_FIRST) || (src == `WLTE_SRC_SECOND);
        end
    endfunction

    // Pattern match of one logic slot against its selected port
    function slot_match;
        input [17:0] slot;
        input [7:0] p_first;
        input [7:0] p_second;
        input all_mode;
        reg [7:0] bits;
        reg [7:0] care;
        reg [7:0] sat;
        begin
            // Packed positions: the slot register drops the unused bus bits
            care = slot[`WLTE_SLOT_CARE_MSB:`WLTE_SLOT_CARE_LSB];
            // Port chosen by the slot source
            if (slot[`WLTE_LOG_SRC_MSB:`WLTE_LOG_SRC_LSB] == `WLTE_SRC_SECOND) begin
                bits = p_second;
            end else begin
                bits = p_first;
            end
            // A cared bit is met when it equals its required value
            sat = ~(bits ^ slot[`WLTE_SLOT_VAL_MSB:`WLTE_SLOT_VAL_LSB]) & care;
            if (all_mode) begin
                // Don't-care bits count as met
                slot_match = &(sat | ~care);
            end else begin
                // Don't-care bits can never fire the trigger
                slot_match = |sat;
            end
        end
    endfunction

    // Pins cross into the clock domain before anything reads them
    // The two flops cost two cycles of latency on the logic ports; a pattern
    // must stand that long before a sample to be seen.
    wlte_sync2 u_sync_first (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i(logic_port_first_i),
        .sync_o(first_port_bits)
    );

    wlte_sync2 u_sync_second (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i(logic_port_second_i),
        .sync_o(second_port_bits)
    );

    // Analog source selection
    // The channels come from the same clock domain, so no synchroniser here
    reg [7:0] ch_value;
    always @* begin
        case (ch_sel)
            2'h0: ch_value = ch0_value_i;
            2'h1: ch_value = ch1_value_i;
            2'h2: ch_value = ch2_value_i;
            2'h3: ch_value = ch3_value_i;
            default: ch_value = ch0_value_i;
        endcase
    end

    // Comparators against both levels
    // Both comparisons are strict, so a value sitting on a level never counts
    wire above_lo;
    wire below_lo;
    wire above_hi;
    wire below_hi;

    wlte_level_cmp u_cmp_lo (
        .value_i(ch_value),
        .level_i(level_lo),
        .above_o(above_lo),
        .below_o(below_lo)
    );

    wlte_level_cmp u_cmp_hi (
        .value_i(ch_value),
        .level_i(level_hi),
        .above_o(above_hi),
        .below_o(below_hi)
    );

    // Analog condition of the selected channel
    // Bi-slope falls through the lower level and rises through the upper one;
    // the first sample after reset only primes the history, it cannot fire.
    reg ana_res;
    always @* begin
        ana_res = 1'b0;
        if (trig_type == `WLTE_TYPE_BISLOPE) begin
            // Combining flag is ignored: either crossing fires
            ana_res = prev_valid &
                ((~prev_below_lo & below_lo) | (~prev_above_hi & above_hi));
        end else if (comb_and) begin
            // Inside the window
            ana_res = above_lo & below_hi;
        end else begin
            // Outside the window
            ana_res = below_lo | above_hi;
        end
    end

    // Which conditions take part; logic slots only in window type
    // Term 0 is the analog channel, terms 1 and 2 the two logic slots
    wire is_window = (trig_type == `WLTE_TYPE_WINDOW);
    wire [2:0] cond_en = {slot_enabled(logic1) & is_window,
                          slot_enabled(logic0) & is_window,
                          ana_en};
    wire [2:0] cond_res = {slot_match(logic1, first_port_bits, second_port_bits, comb_and),
                           slot_match(logic0, first_port_bits, second_port_bits, comb_and),
                           ana_res};

    // Combine enabled conditions; bi-slope has only its analog term
    // With nothing enabled the AND form would be vacuously true, hence the guard
    reg next_cond;
    always @* begin
        if (comb_and && is_window) begin
            // Needs at least one enabled term; one term gives the same as OR
            next_cond = (|cond_en) & (&(cond_res | ~cond_en));
        end else begin
            next_cond = |(cond_res & cond_en);
        end
    end

    // Sample-rate evaluation and rising-edge trigger pulse
    // Between samples every piece of history holds, so a slow sample rate
    // sees exactly the same edges as a fast one.
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            cond_q <= 1'b0;
            prev_valid <= 1'b0;
            prev_below_lo <= 1'b0;
            prev_above_hi <= 1'b0;
            trig_pulse_o <= 1'b0;
        end else begin
            trig_pulse_o <= 1'b0;
            if (sample_en_i) begin
                // Pulse only when the condition goes from false to true
                trig_pulse_o <= next_cond & ~cond_q;
                cond_q <= next_cond;
                prev_valid <= 1'b1;
                prev_below_lo <= below_lo;
                prev_above_hi <= above_hi;
            end
        end
    end

    // Event sources for the sticky status
    // The trigger event is the same term that raises the pulse
    wire ev_trig = sample_en_i & next_cond & ~cond_q;
    // A level write leaving the window empty is flagged, not corrected
    wire lvl_wr = wr_done && (avs_address_i == `WLTE_OFS_LEVELS);
    wire [7:0] wr_lo = clamp_level(avs_writedata_i[`WLTE_LVL_LO_MSB:`WLTE_LVL_LO_LSB]);
    wire [7:0] wr_hi = clamp_level(avs_writedata_i[`WLTE_LVL_HI_MSB:`WLTE_LVL_HI_LSB]);
    wire ev_order = lvl_wr & ~($signed(wr_lo) < $signed(wr_hi));
    wire [1:0] ev_vec = {ev_order, ev_trig};

    // Register writes
    // Status is written in its own process, so only the clear path reaches it
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            ctrl <= `WLTE_RST_CTRL;
            level_lo <= `WLTE_RST_LEVEL_LO;
            level_hi <= `WLTE_RST_LEVEL_HI;
            logic0 <= `WLTE_RST_LOGIC;
            logic1 <= `WLTE_RST_LOGIC;
            mask <= `WLTE_RST_EVENTS;
        end else if (wr_done) begin
            case (avs_address_i)
                `WLTE_OFS_CTRL: ctrl <= avs_writedata_i[5:0];
                `WLTE_OFS_LEVELS: begin
                    // Levels saturate to the percent range
                    level_lo <= wr_lo;
                    level_hi <= wr_hi;
                end
                `WLTE_OFS_LOGIC0: logic0 <= {avs_writedata_i[23:8], avs_writedata_i[1:0]};
                `WLTE_OFS_LOGIC1: logic1 <= {avs_writedata_i[23:8], avs_writedata_i[1:0]};
                `WLTE_OFS_MASK: mask <= avs_writedata_i[1:0];
                default: begin
                    // Unmapped or read-only offsets ignore writes
                end
            endcase
        end
    end

    // Sticky status: a new event wins over a write-one clear
    // Losing an event to a clear in the same cycle would hide a trigger from software
    wire status_wr = wr_done && (avs_address_i == `WLTE_OFS_STATUS);
    wire [1:0] clr_vec = status_wr ? avs_writedata_i[1:0] : 2'h0;
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            status <= `WLTE_RST_EVENTS;
            irq_o <= 1'b0;
        end else begin
            status <= (status & ~clr_vec) | ev_vec;
            // Interrupt follows the stored status one cycle later
            irq_o <= |(status & mask);
        end
    end

    // Read multiplexer
    // Unused bits read as zero, except control bit 3, which reads back as written
    reg [31:0] rd_mux;
    always @* begin
        case (avs_address_i)
            `WLTE_OFS_CTRL: rd_mux = {26'h0000000, ctrl};
            `WLTE_OFS_LEVELS: rd_mux = {16'h0000, level_hi, level_lo};
            `WLTE_OFS_LOGIC0: rd_mux = {8'h00, logic0[17:2], 6'h00, logic0[1:0]};
            `WLTE_OFS_LOGIC1: rd_mux = {8'h00, logic1[17:2], 6'h00, logic1[1:0]};
            `WLTE_OFS_STATUS: rd_mux = {30'h00000000, status};
            `WLTE_OFS_MASK: rd_mux = {30'h00000000, mask};
            // Live view of the condition and the port bits
            `WLTE_OFS_STATE: rd_mux = {8'h00, second_port_bits, first_port_bits, 7'h00, cond_q};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // Bus handshake: every access completes on the second edge it is held
    // One fixed stall cycle lets read data come from a flop; the price is
    // two clocks per access even for back-to-back transfers.
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h00000000;
        end else if (bus_req && avs_waitrequest_o) begin
            avs_waitrequest_o <= 1'b0;
            if (avs_read_i) begin
                avs_readdata_o <= rd_mux;
            end
        end else begin
            // Back to stalling after each completed access
            avs_waitrequest_o <= 1'b1;
        end
    end
endmodule // wlte_trigger

// ===== testbench/wlte_trigger_checker.sv
// Port-level assertions for the trigger evaluator
`timescale 1ns/1ps
module wlte_trigger_checker (
    input wire clk_i,
    input wire sys_rst_i,
    input wire [4:0] avs_address_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire avs_read_i,
    input wire avs_waitrequest_o,
    input wire sample_en_i,
    input wire trig_pulse_o,
    input wire irq_o
);
    reg [1:0] ctrl; // Shadow of analog enable and trigger type
    reg [1:0] src0; // Shadow of the slot sources
    reg [1:0] src1;
    reg mask0; // Shadow of the trigger event mask
    wire wr_done = avs_write_i && !avs_waitrequest_o;
    wire no_slot = (src0 == 2'h0 || src0 == 2'h3) && (src1 == 2'h0 || src1 == 2'h3);
    // Follow the configuration on the very edge the design applies it, so both agree per sample
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            ctrl <= 2'h0;
            src0 <= 2'h0;
            src1 <= 2'h0;
            mask0 <= 1'b0;
        end else if (wr_done) begin
            case (avs_address_i)
                5'h00: ctrl <= avs_writedata_i[1:0];
                5'h08: src0 <= avs_writedata_i[1:0];
                5'h0c: src1 <= avs_writedata_i[1:0];
                5'h14: mask0 <= avs_writedata_i[0];
                default: ;
            endcase
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    pulse_single_a: assert property (trig_pulse_o |=> !trig_pulse_o)
        else $error("trigger pulse wider than one cycle");
    pulse_cause_a: assert property (trig_pulse_o |-> $past(sample_en_i))
        else $error("trigger pulse without a sample");
    bislope_logic_a: assert property (sample_en_i && ctrl == 2'h2 |=> !trig_pulse_o)
        else $error("logic slot counted in bi-slope type");
    no_terms_a: assert property (sample_en_i && !ctrl[0] && no_slot |=> !trig_pulse_o)
        else $error("trigger with no enabled term");
    irq_follow_a: assert property (trig_pulse_o && mask0 |=> irq_o)
        else $error("unmasked event did not raise interrupt");
    reset_quiet_a: assert property (disable iff (1'b0) sys_rst_i |=> !trig_pulse_o && !irq_o && avs_waitrequest_o)
        else $error("outputs active after reset edge");
    bus_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("bus request not answered in one cycle");
    bus_release_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
endmodule // wlte_trigger_checker

bind wlte_trigger wlte_trigger_checker wlte_trigger_checker_inst (.clk_i, .sys_rst_i, .avs_address_i, .avs_write_i,
    .avs_writedata_i, .avs_read_i, .avs_waitrequest_o, .sample_en_i, .trig_pulse_o, .irq_o);

// ===== testbench/wlte_src_model.sv
// Model of the sampled measurement channels and the logic input pins
`timescale 1ns/1ps
module wlte_src_model (
    input wire clk_i,
    output reg sample_en_o,
    output reg [7:0] ch0_o,
    output reg [7:0] ch1_o,
    output reg [7:0] ch2_o,
    output reg [7:0] ch3_o,
    output reg [7:0] first_o,
    output reg [7:0] second_o
);
    // Quiet outputs from time zero
    initial begin
        sample_en_o = 1'b0;
        {ch0_o, ch1_o, ch2_o, ch3_o, first_o, second_o} = 48'h0;
    end
    // Present one sample; pins settle three cycles early to cover the two-flop synchroniser
    task drive(input logic [7:0] v, input logic [7:0] pa, input logic [7:0] pb);
        @(posedge clk_i);
        ch0_o <= v;
        ch1_o <= ~v; // Channels 1 and 2 always differ, channel 3 unless v is 0 or 8'h80, so a wrong select shows
        ch2_o <= v ^ 8'h55;
        ch3_o <= -v;
        first_o <= pa;
        second_o <= pb;
        repeat (3) @(posedge clk_i);
        sample_en_o <= 1'b1;
        @(posedge clk_i);
        sample_en_o <= 1'b0;
    endtask
endmodule // wlte_src_model

// ===== testbench/tb_top.sv
// Self-checking bench for the trigger evaluator
`timescale 1ns/1ps
module tb_top;
    reg clk_i;
    reg sys_rst_i;
    reg [4:0] avs_address_i;
    reg avs_read_i;
    reg avs_write_i;
    reg [31:0] avs_writedata_i;
    wire [31:0] avs_readdata_o;
    wire avs_waitrequest_o;
    wire sample_en;
    wire [7:0] ch0, ch1, ch2, ch3, port_first, port_second;
    wire trig_pulse_o;
    wire irq_o;
    integer num_errors;
    integer check_count;
    integer c;
    wlte_trigger wlte_trigger_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .sample_en_i(sample_en),
        .ch0_value_i(ch0), .ch1_value_i(ch1), .ch2_value_i(ch2), .ch3_value_i(ch3),
        .logic_port_first_i(port_first), .logic_port_second_i(port_second),
        .trig_pulse_o(trig_pulse_o), .irq_o(irq_o));
    wlte_src_model wlte_src_model_inst (.clk_i(clk_i), .sample_en_o(sample_en), .ch0_o(ch0), .ch1_o(ch1),
        .ch2_o(ch2), .ch3_o(ch3), .first_o(port_first), .second_o(port_second));
    // Free-running 100 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Count and report one comparison
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // One Avalon transfer, held until waitrequest is sampled low; read data taken at that edge
    task bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [31:0] e);
        integer n;
        @(posedge clk_i);
        avs_read_i <= !w;
        avs_write_i <= w;
        avs_address_i <= a;
        avs_writedata_i <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n = n + 1;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        if (avs_waitrequest_o !== 1'b0) begin
            num_errors = num_errors + 1;
            end_sim;
        end else if (!w)
            chk(avs_readdata_o, e);
    endtask
    task wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 32'h0);
    endtask
    task rd(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, e);
    endtask
    // One sample, then the pulse is looked at in the cycle it stands
    task st(input logic [7:0] v, input logic [7:0] pa, input logic [7:0] pb, input logic e);
        wlte_src_model_inst.drive(v, pa, pb);
        #1;
        chk({31'h0, trig_pulse_o}, {31'h0, e});
    endtask
    // Single exit point with the verdict
    task end_sim;
        $display("Errors %0d, checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        num_errors = 0;
        check_count = 0;
        {avs_address_i, avs_read_i, avs_write_i, avs_writedata_i} = 39'h0;
        sys_rst_i = 1'b1;
        repeat (20) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd(5'h00, 32'h0);
        rd(5'h04, 32'h32ce);
        rd(5'h1c, 32'h0);
        wr(5'h04, 32'h7f80);
        rd(5'h04, 32'h649c);
        wr(5'h04, 32'h0510);
        rd(5'h10, 32'h2);
        wr(5'h10, 32'h2);
        rd(5'h10, 32'h0);
        wr(5'h04, 32'h32ce);
        wr(5'h14, 32'h1);
        wr(5'h00, 32'h05); // Window, AND, analog only
        st(8'h00, 8'h0, 8'h0, 1'b1);
        @(posedge clk_i);
        #1 chk({31'h0, irq_o}, 32'h1);
        st(8'h0a, 8'h0, 8'h0, 1'b0);
        st(8'h32, 8'h0, 8'h0, 1'b0);
        st(8'h14, 8'h0, 8'h0, 1'b1);
        st(8'hce, 8'h0, 8'h0, 1'b0);
        wr(5'h10, 32'h1);
        rd(5'h10, 32'h0);
        chk({31'h0, irq_o}, 32'h0);
        wr(5'h14, 32'h0); // Events masked from here on
        wr(5'h00, 32'h01);
        st(8'hc0, 8'h0, 8'h0, 1'b1);
        st(8'h00, 8'h0, 8'h0, 1'b0);
        st(8'h32, 8'h0, 8'h0, 1'b0);
        st(8'h33, 8'h0, 8'h0, 1'b1);
        for (c = 3; c < 8; c = c + 4) begin
            wr(5'h00, 32'(c));
            st(8'h00, 8'h0, 8'h0, 1'b0);
            st(8'h40, 8'h0, 8'h0, 1'b1);
            st(8'h50, 8'h0, 8'h0, 1'b0);
            st(8'h00, 8'h0, 8'h0, 1'b0);
            st(8'hc0, 8'h0, 8'h0, 1'b1);
        end
        wr(5'h00, 32'h04); // Logic only, AND
        wr(5'h08, 32'h00050f01);
        st(8'h0, 8'hf4, 8'h00, 1'b0);
        st(8'h0, 8'h05, 8'h00, 1'b1);
        st(8'h0, 8'hf4, 8'h00, 1'b0);
        st(8'h0, 8'hf5, 8'h00, 1'b1);
        wr(5'h0c, 32'h00808002);
        st(8'h0, 8'h05, 8'h00, 1'b0);
        st(8'h0, 8'h05, 8'h80, 1'b1);
        wr(5'h00, 32'h00);
        st(8'h0, 8'h0a, 8'h00, 1'b0);
        st(8'h0, 8'h0b, 8'h00, 1'b1);
        st(8'h0, 8'h0a, 8'h00, 1'b0);
        wr(5'h08, 32'h00050f00);
        st(8'h0, 8'h05, 8'h00, 1'b0);
        st(8'h0, 8'h00, 8'h80, 1'b1);
        wr(5'h00, 32'h04);
        st(8'h0, 8'h00, 8'h00, 1'b0);
        st(8'h0, 8'h00, 8'h80, 1'b1);
        wr(5'h00, 32'h06);
        st(8'h0, 8'h00, 8'h00, 1'b0);
        st(8'h0, 8'h00, 8'h80, 1'b0);
        wr(5'h0c, 32'h0); // Both slots off, analog off: no term left
        wr(5'h00, 32'h04);
        st(8'h0, 8'h05, 8'h80, 1'b0);
        wr(5'h00, 32'h21); // Window, OR, channel 2 selected
        st(8'h55, 8'h0, 8'h0, 1'b0);
        st(8'h00, 8'h0, 8'h0, 1'b1);
        rd(5'h10, 32'h1);
        chk({31'h0, irq_o}, 32'h0);
        end_sim;
    end
endmodule // tb_top
